/* spm_pin_model.sv */
// pin model: strap resistors on the sensing pins and the attached ide drive
module spm_pin_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // resistor levels {dma_ack_zero_n, read strobe, write strobe, rom select}
    input wire logic [3:0] strap,
    // design drivers of the same four pins
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // resolved pin levels
    output logic [3:0] pin_lvl,
    // read strobes accepted by the drive
    output logic [7:0] rd_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // wire resolution and drive
    // ------------------------------------------------------------
    logic rd_q; // last accepted read strobe level
    // a released pin settles to its resistor level, never to a stale value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_lvl[i] = pin_oe[i] ? pin_out[i] : strap[i];
        end
    end
    // drive counts falling read strobes; lows while floated are ignored
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_count <= 8'h00;
            rd_q <= 1'b1;
        end else begin
            rd_q <= pin_oe[2] ? pin_lvl[2] : 1'b1;
            if (rd_q && !pin_lvl[2] && pin_oe[2]) begin
                rd_count <= rd_count + 8'h01;
            end
        end
    end
endmodule

/* spm_pkg.sv */
// constants and types for the strap sampler and ide pin mux
package spm_pkg;
    // ------------------------------------------------------------
    // strap sampling timing
    // ------------------------------------------------------------
    // cycles after reset release before straps are taken (covers the 3-stage sync)
    localparam logic [2:0] STRAP_WAIT_CYC = 3'h5;
    // ------------------------------------------------------------
    // synchronised pin vector layout
    // ------------------------------------------------------------
    localparam int NPINS = 10;
    localparam int PIN_DMA_ACK_ZERO_N = 0;
    localparam int PIN_DRD = 1;
    localparam int PIN_DWR = 2;
    localparam int PIN_ROM_SELECT_N = 3;
    localparam int PIN_NOWS = 4;
    localparam int PIN_DRQ7 = 5;
    localparam int PIN_DHI0 = 6;
    localparam int PIN_DHI2 = 8;
    // inactive pin levels loaded on reset, so no false change follows release
    localparam logic [NPINS-1:0] PIN_IDLE = 10'h3df;
    // ------------------------------------------------------------
    // bit positions inside sa_hi (sa[23:16])
    // ------------------------------------------------------------
    localparam int SA_CS1 = 0;
    localparam int SA_CS3 = 1;
    localparam int SA_RD = 2;
    localparam int SA_WR = 3;
    localparam int SA_DA_LSB = 4;
    localparam int SA_DACK = 7;
    // ------------------------------------------------------------
    // extended mode encodings and reset values
    // ------------------------------------------------------------
    localparam int NACKS = 7;
    localparam logic [2:0] DACK_CODE_IDLE = 3'h7;
    localparam logic [3:0] DHI_OE_EXT = 4'ha;
    localparam logic [7:0] SA_RST = 8'h00;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {SPM_SAMPLE, SPM_RUN} spm_state_e;
    typedef struct packed {
        logic pci_3v3;
        logic extended;
        logic rom_en;
        logic test_tristate;
        logic test_nand;
    } spm_straps_s;
    typedef struct packed {
        logic cycle;
        logic cable;
        logic cs1_n;
        logic cs3_n;
        logic [2:0] addr;
        logic dack_n;
        logic rd_n;
        logic wr_n;
    } spm_ide_s;
endpackage

/* spm_strap_ide_mux.sv */
// strap sampling at reset release and ide control routing onto upper isa address pins
module spm_strap_ide_mux
    import spm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // strap sensing pins
    input wire logic dma_ack_zero_n_in,
    input wire logic drive_read_strobe_n_in,
    input wire logic drive_write_strobe_n_in,
    input wire logic rom_select_n_in,
    output logic drive_read_strobe_n_out,
    output logic drive_read_strobe_n_oe,
    output logic drive_write_strobe_n_out,
    output logic drive_write_strobe_n_oe,
    output logic rom_select_n_out,
    output logic rom_select_n_oe,
    // dma acknowledge pins (dma_ack_zero_n..2 and dack3,5,6,7)
    output logic [2:0] dack_lo_out,
    output logic [2:0] dack_lo_oe,
    input wire logic [3:0] dack_hi_in,
    output logic [3:0] dack_hi_out,
    output logic [3:0] dack_hi_oe,
    // shared isa pins
    input wire logic nows_n_in,
    input wire logic drq7_in,
    output logic [7:0] sa_hi_out,
    output logic sa_hi_oe,
    // bridge isa and dma side
    input wire logic [7:0] isa_addr_hi,
    input wire logic isa_addr_oe,
    input wire logic [6:0] dma_ack_n,
    output logic nows_to_isa_n,
    output logic drq7_to_isa,
    // extra pci request/grant pairs
    input wire logic [1:0] ext_gnt_n,
    output logic [1:0] ext_req_n,
    // ide controller side
    input wire spm_ide_s ide,
    input wire logic ide_pin_buffer_sel,
    input wire logic [3:0] ide_timing_low,
    output logic cable0_dma_request,
    output logic cable1_dma_request,
    // rom side
    input wire logic rom_cs_n,
    input wire logic [31:0] rom_reg_rdata,
    output logic [31:0] rom_reg_rdata_q,
    // sampled strap status
    output spm_straps_s straps
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // encode one active-low ack of seven onto a 3-bit decoder code
    function automatic logic [2:0] dack_encode(input logic [6:0] acks_n);
        logic [2:0] code;
        code = DACK_CODE_IDLE;
        for (int i = NACKS - 1; i >= 0; i--) begin
            if (!acks_n[i]) begin
                code = 3'(i);
            end
        end
        return code;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [NPINS-1:0] pin_raw; // asynchronous pin levels
    logic [NPINS-1:0] sync1_r, sync2_r, sync3_r; // three-stage chain
    logic [NPINS-1:0] pin_q_r, pin_q_nxt; // filtered level
    assign pin_raw = {dack_hi_in, drq7_in, nows_n_in, rom_select_n_in,
                      drive_write_strobe_n_in, drive_read_strobe_n_in, dma_ack_zero_n_in};

    // a change is accepted once stages two and three agree
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            pin_q_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : pin_q_r[i];
        end
    end

    // sync registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= PIN_IDLE;
            sync2_r <= PIN_IDLE;
            sync3_r <= PIN_IDLE;
            pin_q_r <= PIN_IDLE;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_q_r <= pin_q_nxt;
        end
    end

    // ------------------------------------------------------------
    // strap sampling state
    // ------------------------------------------------------------
    spm_state_e state_r, state_nxt; // sampling or running
    logic [2:0] wait_r, wait_nxt; // settle counter
    spm_straps_s straps_r, straps_nxt; // latched options

    // wait for the sync chain, then capture once
    always_comb begin
        state_nxt = state_r;
        wait_nxt = wait_r;
        straps_nxt = straps_r;
        case (state_r)
            SPM_SAMPLE: begin
                if (wait_r == STRAP_WAIT_CYC) begin
                    state_nxt = SPM_RUN;
                    straps_nxt.pci_3v3 = !pin_q_r[PIN_DMA_ACK_ZERO_N];
                    straps_nxt.extended = pin_q_r[PIN_DRD] && !pin_q_r[PIN_DWR];
                    straps_nxt.rom_en = pin_q_r[PIN_ROM_SELECT_N];
                    straps_nxt.test_tristate = pin_q_r[PIN_DWR] && !pin_q_r[PIN_DRD];
                    straps_nxt.test_nand = pin_q_r[PIN_DWR] && pin_q_r[PIN_DRD];
                end else begin
                    wait_nxt = wait_r + 3'h1;
                end
            end
            SPM_RUN: begin
                // held until the next hard reset
                state_nxt = SPM_RUN;
            end
            default: begin
                state_nxt = SPM_SAMPLE;
            end
        endcase
    end

    // strap registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= SPM_SAMPLE;
            wait_r <= 3'h0;
            straps_r <= '0;
        end else begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            straps_r <= straps_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------
    logic run, active, buffered, nows_as_drq, nand_tree; // mode terms
    logic [7:0] sa_nxt;
    logic sa_oe_nxt, drd_nxt, dwr_nxt, pins_oe_nxt, rom_out_nxt, rom_oe_nxt;
    logic [2:0] dlo_nxt;
    logic [3:0] dhi_nxt, dhi_oe_nxt;
    logic [1:0] req_nxt;
    logic c0_nxt, c1_nxt, nows_isa_nxt, drq7_isa_nxt;
    logic [31:0] rom_rd_nxt;
    assign run = (state_r == SPM_RUN);
    assign active = run && !straps_r.test_tristate && !straps_r.test_nand;
    assign buffered = ide_pin_buffer_sel;
    assign nows_as_drq = |ide_timing_low;
    // every synced pin except rom_select_n feeds the tree
    assign nand_tree = !(&(pin_q_r | (NPINS'(1) << PIN_ROM_SELECT_N)));

    // output mux for all driven pins
    always_comb begin
        // sa lines carry isa address outside ide cycles
        sa_nxt = isa_addr_hi;
        if (ide.cycle) begin
            sa_nxt[SA_CS1] = ide.cs1_n;
            sa_nxt[SA_CS3] = ide.cs3_n;
            sa_nxt[SA_DA_LSB +: 3] = ide.addr;
            sa_nxt[SA_DACK] = ide.dack_n;
            if (buffered) begin
                sa_nxt[SA_RD] = ide.rd_n;
                sa_nxt[SA_WR] = ide.wr_n;
            end
        end
        sa_oe_nxt = active && (isa_addr_oe || ide.cycle);
        // dedicated pins: buffer enables or strobes
        if (buffered) begin
            drd_nxt = !(ide.cycle && !ide.cable);
            dwr_nxt = !(ide.cycle && ide.cable);
        end else begin
            drd_nxt = ide.cycle ? ide.rd_n : 1'b1;
            dwr_nxt = ide.cycle ? ide.wr_n : 1'b1;
        end
        // pins float while sampling and in either test mode
        pins_oe_nxt = active;
        // dma ack pins: plain or encoded with freed req/gnt
        if (straps_r.extended) begin
            dlo_nxt = dack_encode(dma_ack_n);
            dhi_nxt = {ext_gnt_n[1], 1'b1, ext_gnt_n[0], 1'b1};
            dhi_oe_nxt = active ? DHI_OE_EXT : 4'h0;
            req_nxt = {pin_q_r[PIN_DHI2], pin_q_r[PIN_DHI0]};
        end else begin
            dlo_nxt = dma_ack_n[2:0];
            dhi_nxt = dma_ack_n[6:3];
            dhi_oe_nxt = {4{active}};
            req_nxt = 2'h3;
        end
        // rom select or nand tree output
        if (run && straps_r.test_nand) begin
            rom_out_nxt = nand_tree;
            rom_oe_nxt = 1'b1;
        end else begin
            rom_out_nxt = straps_r.rom_en ? rom_cs_n : 1'b1;
            rom_oe_nxt = active && straps_r.rom_en;
        end
        rom_rd_nxt = straps_r.rom_en ? rom_reg_rdata : 32'h0000_0000;
        // drive dma request inputs taken from isa pins
        c0_nxt = nows_as_drq && pin_q_r[PIN_NOWS];
        nows_isa_nxt = nows_as_drq ? 1'b1 : pin_q_r[PIN_NOWS];
        c1_nxt = buffered && pin_q_r[PIN_DRQ7];
        drq7_isa_nxt = buffered ? 1'b0 : pin_q_r[PIN_DRQ7];
    end

    // output registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sa_hi_out <= SA_RST;
            sa_hi_oe <= 1'b0;
            drive_read_strobe_n_out <= 1'b1;
            drive_write_strobe_n_out <= 1'b1;
            drive_read_strobe_n_oe <= 1'b0;
            drive_write_strobe_n_oe <= 1'b0;
            dack_lo_out <= DACK_CODE_IDLE;
            dack_lo_oe <= 3'h0;
            dack_hi_out <= 4'hf;
            dack_hi_oe <= 4'h0;
            ext_req_n <= 2'h3;
            rom_select_n_out <= 1'b1;
            rom_select_n_oe <= 1'b0;
            rom_reg_rdata_q <= 32'h0000_0000;
            cable0_dma_request <= 1'b0;
            cable1_dma_request <= 1'b0;
            nows_to_isa_n <= 1'b1;
            drq7_to_isa <= 1'b0;
            straps <= '0;
        end else begin
            sa_hi_out <= sa_nxt;
            sa_hi_oe <= sa_oe_nxt;
            drive_read_strobe_n_out <= drd_nxt;
            drive_write_strobe_n_out <= dwr_nxt;
            drive_read_strobe_n_oe <= pins_oe_nxt;
            drive_write_strobe_n_oe <= pins_oe_nxt;
            dack_lo_out <= dlo_nxt;
            dack_lo_oe <= {3{pins_oe_nxt}};
            dack_hi_out <= dhi_nxt;
            dack_hi_oe <= dhi_oe_nxt;
            ext_req_n <= req_nxt;
            rom_select_n_out <= rom_out_nxt;
            rom_select_n_oe <= rom_oe_nxt;
            rom_reg_rdata_q <= rom_rd_nxt;
            cable0_dma_request <= c0_nxt;
            cable1_dma_request <= c1_nxt;
            nows_to_isa_n <= nows_isa_nxt;
            drq7_to_isa <= drq7_isa_nxt;
            straps <= straps_r;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_FLOAT_SAMPLE: assert property ((state_r == SPM_SAMPLE) |=>
        (!drive_read_strobe_n_oe && !drive_write_strobe_n_oe && !rom_select_n_oe && dack_lo_oe == 3'h0))
        else $error("strap pin driven during sampling");
    AST_STRAP_HOLD: assert property (run |=> $stable(straps_r) && run)
        else $error("strap value changed after capture");
    AST_STRAP_FIXED: assert property (run ##1 run |-> straps == $past(straps_r))
        else $error("strap status does not follow latch");
    AST_PCI_3V3: assert property ((run && $past(state_r) == SPM_SAMPLE) |->
        straps_r.pci_3v3 == !$past(pin_q_r[PIN_DMA_ACK_ZERO_N]))
        else $error("3.3v strap mis-sampled");
    AST_EXT_MODE: assert property ((run && $past(state_r) == SPM_SAMPLE) |->
        straps_r.extended == ($past(pin_q_r[PIN_DRD]) && !$past(pin_q_r[PIN_DWR])))
        else $error("extended strap mis-sampled");
    AST_ROM_ZERO: assert property (!straps_r.rom_en |=> rom_reg_rdata_q == 32'h0000_0000)
        else $error("rom register nonzero with rom disabled");
    AST_TRISTATE: assert property ((run && straps_r.test_tristate) |=>
        (!sa_hi_oe && !rom_select_n_oe && dack_hi_oe == 4'h0 && !drive_read_strobe_n_oe))
        else $error("output driven in tristate test");
    AST_NAND: assert property ((run && straps_r.test_nand) |=>
        (rom_select_n_oe && rom_select_n_out == $past(nand_tree)))
        else $error("nand tree output wrong");
    AST_SINGLE_CABLE: assert property ((active && ide.cycle && !buffered) |=>
        (sa_hi_oe && sa_hi_out[SA_CS1] == $past(ide.cs1_n) && sa_hi_out[SA_DACK] == $past(ide.dack_n)
         && drive_read_strobe_n_out == $past(ide.rd_n)))
        else $error("single cable mapping wrong");
    AST_BUFFERED: assert property ((active && ide.cycle && buffered) |=>
        (sa_hi_out[SA_RD] == $past(ide.rd_n) && sa_hi_out[SA_WR] == $past(ide.wr_n)
         && drive_read_strobe_n_out == $past(ide.cable)))
        else $error("buffered cable mapping wrong");
    AST_NOWS_DRQ: assert property (nows_as_drq |=>
        (nows_to_isa_n && cable0_dma_request == $past(pin_q_r[PIN_NOWS])))
        else $error("nows not routed as drive request");
    AST_DACK_ENC: assert property ((active && straps_r.extended) |=>
        (dack_lo_out == dack_encode($past(dma_ack_n)) && dack_hi_oe == DHI_OE_EXT))
        else $error("extended dack encoding wrong");

    COV_EXTENDED: cover property (run && straps_r.extended && dma_ack_n != 7'h7f);
    COV_NAND: cover property (run && straps_r.test_nand);
    COV_BUF_CYCLE: cover property (active && buffered && ide.cycle && ide.cable);
    COV_SINGLE_DRQ: cover property (active && nows_as_drq && pin_q_r[PIN_NOWS]);
endmodule

/* test_spm_strap_ide_mux.sv */
// self-checking bench for the strap sampler and ide pin mux
module test_spm_strap_ide_mux import spm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] strap = 4'h8; // resistor levels, see model
    logic [3:0] pin_out, pin_oe, pin_lvl;
    logic [7:0] rd_count;
    logic drive_read_strobe_n_out, drive_read_strobe_n_oe;
    logic drive_write_strobe_n_out, drive_write_strobe_n_oe;
    logic rom_select_n_out, rom_select_n_oe;
    logic [2:0] dack_lo_out, dack_lo_oe;
    logic [3:0] dack_hi_in = 4'hf;
    logic [3:0] dack_hi_out, dack_hi_oe;
    logic nows_n_in = 1'b1;
    logic drq7_in = 1'b0;
    logic [7:0] sa_hi_out;
    logic sa_hi_oe;
    logic [7:0] isa_addr_hi = 8'h00;
    logic isa_addr_oe = 1'b0;
    logic [6:0] dma_ack_n = 7'h7f;
    logic nows_to_isa_n, drq7_to_isa;
    logic [1:0] ext_gnt_n = 2'h3;
    logic [1:0] ext_req_n;
    spm_ide_s ide = 10'h0c7; // idle: no cycle, selects and strobes high
    logic ide_pin_buffer_sel = 1'b0;
    logic [3:0] ide_timing_low = 4'h0;
    logic cable0_dma_request, cable1_dma_request;
    logic rom_cs_n = 1'b1;
    logic [31:0] rom_reg_rdata = 32'h0;
    logic [31:0] rom_reg_rdata_q;
    spm_straps_s straps;
    int n_mismatch = 0;
    int check_count = 0;
    // the four strap pins as the model sees them
    assign pin_out = {dack_lo_out[0], drive_read_strobe_n_out, drive_write_strobe_n_out, rom_select_n_out};
    assign pin_oe = {dack_lo_oe[0], drive_read_strobe_n_oe, drive_write_strobe_n_oe, rom_select_n_oe};
    spm_pin_model pins (.ref_clk(ref_clk), .sys_rst(sys_rst), .strap(strap), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_lvl(pin_lvl), .rd_count(rd_count));
    spm_strap_ide_mux dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .dma_ack_zero_n_in(pin_lvl[3]),
        .drive_read_strobe_n_in(pin_lvl[2]), .drive_write_strobe_n_in(pin_lvl[1]),
        .rom_select_n_in(pin_lvl[0]), .drive_read_strobe_n_out(drive_read_strobe_n_out),
        .drive_read_strobe_n_oe(drive_read_strobe_n_oe), .drive_write_strobe_n_out(drive_write_strobe_n_out),
        .drive_write_strobe_n_oe(drive_write_strobe_n_oe), .rom_select_n_out(rom_select_n_out),
        .rom_select_n_oe(rom_select_n_oe), .dack_lo_out(dack_lo_out), .dack_lo_oe(dack_lo_oe),
        .dack_hi_in(dack_hi_in), .dack_hi_out(dack_hi_out), .dack_hi_oe(dack_hi_oe), .nows_n_in(nows_n_in),
        .drq7_in(drq7_in), .sa_hi_out(sa_hi_out), .sa_hi_oe(sa_hi_oe), .isa_addr_hi(isa_addr_hi),
        .isa_addr_oe(isa_addr_oe), .dma_ack_n(dma_ack_n), .nows_to_isa_n(nows_to_isa_n),
        .drq7_to_isa(drq7_to_isa), .ext_gnt_n(ext_gnt_n), .ext_req_n(ext_req_n), .ide(ide),
        .ide_pin_buffer_sel(ide_pin_buffer_sel), .ide_timing_low(ide_timing_low),
        .cable0_dma_request(cable0_dma_request), .cable1_dma_request(cable1_dma_request),
        .rom_cs_n(rom_cs_n), .rom_reg_rdata(rom_reg_rdata), .rom_reg_rdata_q(rom_reg_rdata_q), .straps(straps));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // 100 mhz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end
    // compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // wait n edges, then let their updates settle
    task automatic later(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    // hard reset with the given resistor levels, then past strap capture
    task automatic restart(input logic [3:0] s);
        @(posedge ref_clk);
        strap <= s;
        sys_rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        later(3);
        check(pin_oe, 4'h0);
        later(5);
    endtask
    // bounded wait for the cable 0 request
    task automatic wait_req(input logic want);
        int i;
        for (i = 0; i < 10 && cable0_dma_request !== want; i++) later(1);
        check(cable0_dma_request, want);
        if (i == 10) tally_and_finish();
    endtask
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        // basic mode: no strap selected
        restart(4'b1000);
        check(straps, 5'h00);
        @(posedge ref_clk);
        isa_addr_hi <= 8'ha5;
        isa_addr_oe <= 1'b1;
        dma_ack_n <= 7'h3a;
        rom_reg_rdata <= 32'hdeadbeef;
        rom_cs_n <= 1'b0;
        later(3);
        check(sa_hi_out, 8'ha5);
        check(sa_hi_oe, 1'b1);
        check(dack_lo_out, 3'h2);
        check(dack_hi_out, 4'h7);
        check(rom_reg_rdata_q, 32'h0);
        check({rom_select_n_oe, rom_select_n_out}, 2'h1);
        $display("test basic done");
        // single cable: command then control block select
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            ide <= k ? 10'h2a9 : 10'h269;
            later(2);
            check(sa_hi_out & 8'hf3, k ? 8'h51 : 8'h52);
            check({sa_hi_oe, drive_read_strobe_n_oe, drive_read_strobe_n_out}, 3'h6);
            check({drive_write_strobe_n_oe, drive_write_strobe_n_out}, 2'h3);
            @(posedge ref_clk);
            ide <= 10'h0c7;
            later(2);
        end
        check(rd_count, 8'h02);
        $display("test single cable done");
        // nows as isa input, then as drive request
        @(posedge ref_clk);
        nows_n_in <= 1'b0;
        drq7_in <= 1'b1;
        later(6);
        check(nows_to_isa_n, 1'b0);
        check(cable0_dma_request, 1'b0);
        check({drq7_to_isa, cable1_dma_request}, 2'h2);
        @(posedge ref_clk);
        ide_timing_low <= 4'h8;
        nows_n_in <= 1'b1;
        wait_req(1'b1);
        check(nows_to_isa_n, 1'b1);
        $display("test drive request done");
        // buffered two cable, cable 1 read
        @(posedge ref_clk);
        ide_pin_buffer_sel <= 1'b1;
        ide <= 10'h35d;
        later(6);
        check(sa_hi_out, 8'hba);
        check({drive_read_strobe_n_out, drive_write_strobe_n_out}, 2'h2);
        check({drq7_to_isa, cable1_dma_request}, 2'h1);
        $display("test buffered done");
        // extended mode with 3.3v and rom enabled
        restart(4'b0101);
        check(straps, 5'h1c);
        @(posedge ref_clk);
        dma_ack_n <= 7'h73;
        ext_gnt_n <= 2'b01;
        dack_hi_in <= 4'b1011;
        later(6);
        check(dack_lo_out, 3'h2);
        check({dack_hi_oe, dack_hi_out & 4'ha}, 8'ha2);
        check(ext_req_n, 2'b01);
        check(rom_reg_rdata_q, 32'hdeadbeef);
        check({rom_select_n_oe, rom_select_n_out}, 2'h2);
        @(posedge ref_clk);
        dma_ack_n <= 7'h7f;
        later(2);
        check(dack_lo_out, 3'h7);
        $display("test extended done");
        // tristate test, later pin changes must not matter
        restart(4'b1010);
        check(straps, 5'h02);
        @(posedge ref_clk);
        ide <= 10'h269;
        strap <= 4'b1110;
        later(8);
        check({sa_hi_oe, pin_oe, dack_lo_oe, dack_hi_oe}, 12'h000);
        check(straps, 5'h02);
        $display("test tristate done");
        // nand tree: only rom select drives, a low input forces it high
        restart(4'b1110);
        check(straps, 5'h01);
        @(posedge ref_clk);
        dack_hi_in <= 4'hf;
        later(8);
        check(rom_select_n_out, 1'b0);
        @(posedge ref_clk);
        dack_hi_in <= 4'h0;
        later(8);
        check({sa_hi_oe, pin_oe, dack_lo_oe, dack_hi_oe}, 12'h080);
        check(rom_select_n_out, 1'b1);
        $display("test nand tree done");
        tally_and_finish();
    end
endmodule
